//--- design/mmrd_decoder.sv
// MIDI remote decoder: turns MIDI messages into mixer actions
//
// Overview of operation
// - Channel 1 volume controller sets main output
// - Channel 1 Note On drives monitoring buttons
// - 3E cue main, 5D dim, 5E talkback
// - 2A toggles mono main output
// - 3F to 42 cue phones 1 to 4
// - Controller message parsed as status, number, value
// - Channel groups of four pick fader row
// - Controllers 102-117 only; index from channel, number
// - Sixty-four faders addressable per row
// - Value 40 is 0 dB, 7F max
// - Hostless mode answers and sends notes
// - Hostless mode drops talkback, mono, cue
// - Hostless mode skips middle row; strip controls
// - Hostless mode sends display and LED data
// - Hostless submix taken from stored state
// - Navigation steps one, eight; up/down pick top/bottom row
// - Stop dims, EQ mutes, strips mute/select/record
// - Hostless: 5D dims, 36-3B load setups
// - Surface commands echoed back as feedback
// - Marker every 0.5 s; echo disables control
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/100ps

module mmrd_decoder #(
	parameter int MARKER_CYCLES = mmrd_pkg::MARKER_CYC,
	parameter bit HOSTLESS_AT_RESET = mmrd_pkg::CTRL_HL_RST
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_valid,
	input wire logic i_tx_ready,
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic [7:0] o_tx_data,
	output logic o_tx_valid,
	output logic o_act_we,
	output logic [2:0] o_act_kind,
	output logic [1:0] o_act_row,
	output logic [5:0] o_act_idx,
	output logic [6:0] o_act_val,
	output logic o_main_vol_we,
	output logic [6:0] o_main_vol,
	output logic [2:0] o_cue_sel,
	output logic o_dim,
	output logic o_mono,
	output logic o_talkback,
	output logic o_master_mute,
	output logic o_recall_we,
	output logic [2:0] o_recall_idx,
	output logic [5:0] o_submix,
	output logic [1:0] o_win_row,
	output logic [5:0] o_win_chan,
	output logic o_remote_active,
	output logic o_hostless
);

	localparam int MW = $clog2(MARKER_CYCLES + 1);
	localparam logic [MW-1:0] MARK_LAST = MW'(MARKER_CYCLES - 1);

	// ----------------------------------------------------------------
	// Byte parser
	// ----------------------------------------------------------------
	logic [7:0] run_st_r;
	logic [6:0] d1_r;
	logic have_d1_r;
	logic msg_v_r;
	logic [7:0] m_st_r;
	logic [6:0] m_d1_r;
	logic [6:0] m_d2_r;

	wire rx_status = i_rx_valid & i_rx_data[7];
	wire rx_data = i_rx_valid & ~i_rx_data[7] & run_st_r[7];
	wire rx_done = rx_data & have_d1_r;

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			run_st_r <= 8'h00;
			d1_r <= 7'h00;
			have_d1_r <= 1'b0;
			msg_v_r <= 1'b0;
			m_st_r <= 8'h00;
			m_d1_r <= 7'h00;
			m_d2_r <= 7'h00;
		end else begin
			msg_v_r <= rx_done;
			if (rx_status && i_rx_data < mmrd_pkg::RT_FIRST) begin
				run_st_r <= (i_rx_data < mmrd_pkg::SYS_FIRST) ?
					i_rx_data : 8'h00;
				have_d1_r <= 1'b0;
			end else if (rx_data) begin
				have_d1_r <= ~have_d1_r;
				d1_r <= i_rx_data[6:0];
			end
			if (rx_done) begin
				m_st_r <= run_st_r;
				m_d1_r <= d1_r;
				m_d2_r <= i_rx_data[6:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	logic en_r;
	logic hl_r;
	logic loop_r;
	logic [5:0] submix_r;
	logic [1:0] win_row_r;
	logic [5:0] win_chan_r;

	// ----------------------------------------------------------------
	// Message decode
	// ----------------------------------------------------------------
	wire [3:0] cmd = m_st_r[7:4];
	wire [3:0] ch = m_st_r[3:0];
	wire [6:0] n = m_d1_r;
	wire [6:0] v = m_d2_r;
	wire act = msg_v_r & en_r;
	wire note_on = act & (cmd == mmrd_pkg::CMD_NOTE_ON) & (v != 7'h00);
	wire non1 = note_on & (ch == mmrd_pkg::CH_ONE);
	wire cc = act & (cmd == mmrd_pkg::CMD_CC);
	wire sw = non1 & hl_r;
	wire full = ~hl_r;
	wire [2:0] k = n[2:0];
	wire [5:0] strip = win_chan_r + {3'h0, k};
	wire [5:0] bstrip = win_chan_r + {3'h0, ch[2:0]};

	wire loop_ev = note_on & (ch == mmrd_pkg::MARKER_CH) &
		(n == mmrd_pkg::MARKER_NOTE);
	wire hit_vol = cc & (ch == mmrd_pkg::CH_ONE) &
		(n == mmrd_pkg::CC_VOLUME);
	wire hit_cue = non1 & full & (n == mmrd_pkg::NOTE_CUE_MAIN);
	wire hit_dim = non1 & (n == mmrd_pkg::NOTE_DIM);
	wire hit_talk = non1 & full & (n == mmrd_pkg::NOTE_TALK);
	wire hit_mono = non1 & full & (n == mmrd_pkg::NOTE_MONO);
	wire hit_ph = non1 & full & (n >= mmrd_pkg::NOTE_PH_FIRST) &
		(n <= mmrd_pkg::NOTE_PH_LAST);
	wire [6:0] snap_last = hl_r ? mmrd_pkg::NOTE_SETUP_LAST :
		mmrd_pkg::NOTE_SNAP_LAST;
	wire hit_snap = non1 & (n >= mmrd_pkg::NOTE_SNAP_FIRST) &
		(n <= snap_last);
	wire [6:0] snap_off = n - mmrd_pkg::NOTE_SNAP_FIRST;
	wire [6:0] ph_off = n - mmrd_pkg::NOTE_PH_FIRST;
	wire [6:0] fad_off = n - mmrd_pkg::CC_FADER_FIRST;
	wire hit_fad = cc & (ch <= mmrd_pkg::CH_LAST_FADER) &
		(n >= mmrd_pkg::CC_FADER_FIRST) & (n <= mmrd_pkg::CC_FADER_LAST) &
		~(hl_r & (ch[3:2] == mmrd_pkg::ROW_MID));

	// Control-surface elements, hostless mode only
	wire grp_rec = sw & (n[6:3] == mmrd_pkg::SF_REC[6:3]);
	wire grp_mute = sw & (n[6:3] == mmrd_pkg::SF_MUTE[6:3]);
	wire grp_sel = sw & (n[6:3] == mmrd_pkg::SF_SEL[6:3]);
	wire grp_press = sw & (n[6:3] == mmrd_pkg::SF_PRESS[6:3]);
	wire [6:0] fk_off = n - mmrd_pkg::SF_FKEY;
	wire hit_fkey = sw & (n >= mmrd_pkg::SF_FKEY) &
		(fk_off[2:0] < mmrd_pkg::SF_FKEY_N) & (fk_off[6:3] == 4'h0);
	wire hit_eq = sw & (n == mmrd_pkg::SF_EQ);
	wire hit_stop = sw & (n == mmrd_pkg::SF_STOP);
	wire hit_chl = sw & (n == mmrd_pkg::SF_CH_L);
	wire hit_chr = sw & (n == mmrd_pkg::SF_CH_R);
	wire hit_bkl = sw & (n == mmrd_pkg::SF_BANK_L);
	wire hit_bkr = sw & (n == mmrd_pkg::SF_BANK_R);
	wire hit_up = sw & (n == mmrd_pkg::SF_UP);
	wire hit_dn = sw & (n == mmrd_pkg::SF_DOWN);
	wire hit_bend = act & hl_r & (cmd == mmrd_pkg::CMD_BEND) & ~ch[3];
	wire hit_vpot = cc & hl_r & (n[6:3] == mmrd_pkg::SF_VPOT_CC[6:3]);
	wire nav = hit_chl | hit_chr | hit_bkl | hit_bkr | hit_up | hit_dn;
	wire surf = grp_rec | grp_mute | grp_sel | grp_press | hit_fkey |
		hit_eq | hit_stop | nav | hit_bend | hit_vpot;

	// ----------------------------------------------------------------
	// Navigation window
	// ----------------------------------------------------------------
	wire [5:0] ch_l = (win_chan_r < mmrd_pkg::CHAN_STEP) ? 6'h00 :
		win_chan_r - mmrd_pkg::CHAN_STEP;
	wire [5:0] ch_r = (win_chan_r >= mmrd_pkg::WIN_LAST) ?
		mmrd_pkg::WIN_LAST : win_chan_r + mmrd_pkg::CHAN_STEP;
	wire [5:0] bk_l = (win_chan_r < mmrd_pkg::BANK_STEP) ? 6'h00 :
		win_chan_r - mmrd_pkg::BANK_STEP;
	wire [5:0] bk_r = (win_chan_r >= mmrd_pkg::WIN_LAST -
		mmrd_pkg::BANK_STEP) ? mmrd_pkg::WIN_LAST :
		win_chan_r + mmrd_pkg::BANK_STEP;
	wire [5:0] win_chan_nxt = hit_chl ? ch_l : hit_chr ? ch_r :
		hit_bkl ? bk_l : hit_bkr ? bk_r : win_chan_r;
	wire [1:0] win_row_nxt = hit_up ? mmrd_pkg::ROW_TOP :
		hit_dn ? mmrd_pkg::ROW_BOT : win_row_r;

	// ----------------------------------------------------------------
	// Strip action select
	// ----------------------------------------------------------------
	wire act_we_nxt = hit_fad | hit_bend | hit_vpot | grp_press |
		grp_mute | grp_sel;
	wire [2:0] kind_nxt = hit_vpot ? mmrd_pkg::ACT_PAN_REL :
		grp_press ? mmrd_pkg::ACT_PAN_ABS : grp_mute ? mmrd_pkg::ACT_MUTE :
		grp_sel ? mmrd_pkg::ACT_SEL : mmrd_pkg::ACT_VOL;
	wire [1:0] row_nxt = hit_fad ? ch[3:2] : win_row_r;
	wire [5:0] idx_nxt = hit_fad ? {ch[1:0], fad_off[3:0]} :
		hit_bend ? bstrip : strip;
	wire [6:0] val_nxt = grp_press ? mmrd_pkg::PAN_CENTER :
		(grp_mute | grp_sel) ? 7'h00 : v;
	wire [2:0] cue_code = hit_cue ? mmrd_pkg::CUE_MAIN :
		mmrd_pkg::CUE_PH1 + ph_off[2:0];
	wire [2:0] cue_nxt = (o_cue_sel == cue_code) ? mmrd_pkg::CUE_NONE :
		cue_code;

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_act_we <= 1'b0;
			o_act_kind <= mmrd_pkg::ACT_VOL;
			o_act_row <= mmrd_pkg::ROW_TOP;
			o_act_idx <= 6'h00;
			o_act_val <= mmrd_pkg::VAL_0DB;
			o_main_vol_we <= 1'b0;
			o_main_vol <= mmrd_pkg::VAL_0DB;
			o_cue_sel <= mmrd_pkg::CUE_NONE;
			o_dim <= 1'b0;
			o_mono <= 1'b0;
			o_talkback <= 1'b0;
			o_master_mute <= 1'b0;
			o_recall_we <= 1'b0;
			o_recall_idx <= 3'h0;
			win_row_r <= mmrd_pkg::ROW_TOP;
			win_chan_r <= 6'h00;
		end else begin
			o_act_we <= act_we_nxt;
			if (act_we_nxt) begin
				o_act_kind <= kind_nxt;
				o_act_row <= row_nxt;
				o_act_idx <= idx_nxt;
				o_act_val <= val_nxt;
			end
			o_main_vol_we <= hit_vol;
			if (hit_vol)
				o_main_vol <= v;
			if (hit_cue | hit_ph)
				o_cue_sel <= cue_nxt;
			o_dim <= o_dim ^ (hit_dim | hit_stop);
			o_mono <= (o_mono ^ hit_mono) & full;
			o_talkback <= (o_talkback ^ hit_talk) & full;
			o_master_mute <= o_master_mute ^ hit_eq;
			o_recall_we <= hit_snap | hit_fkey;
			if (hit_snap | hit_fkey)
				o_recall_idx <= hit_fkey ? fk_off[2:0] : snap_off[2:0];
			win_row_r <= win_row_nxt;
			win_chan_r <= win_chan_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	wire wr_ctrl = i_reg_wr & (i_reg_addr == mmrd_pkg::REG_CTRL);
	wire wr_sub = i_reg_wr & (i_reg_addr == mmrd_pkg::REG_SUBMIX);
	wire reen = wr_ctrl & i_reg_wdata[mmrd_pkg::CTRL_EN_BIT];
	wire en_nxt = loop_ev ? 1'b0 : wr_ctrl ?
		i_reg_wdata[mmrd_pkg::CTRL_EN_BIT] : en_r;
	wire loop_nxt = loop_ev | (loop_r & ~reen);
	wire [5:0] sub_nxt = grp_rec ? strip :
		wr_sub ? i_reg_wdata[5:0] : submix_r;
	wire [7:0] rd_mux =
		(i_reg_addr == mmrd_pkg::REG_CTRL) ? {6'h00, hl_r, en_r} :
		(i_reg_addr == mmrd_pkg::REG_STATUS) ? {3'h0, o_master_mute,
			o_talkback, o_mono, o_dim, loop_r} :
		(i_reg_addr == mmrd_pkg::REG_SUBMIX) ? {2'h0, submix_r} :
		(i_reg_addr == mmrd_pkg::REG_WINDOW) ? {win_row_r, win_chan_r} :
		(i_reg_addr == mmrd_pkg::REG_MAIN_VOL) ? {1'b0, o_main_vol} :
		8'h00;

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			en_r <= mmrd_pkg::CTRL_EN_RST;
			hl_r <= HOSTLESS_AT_RESET;
			loop_r <= 1'b0;
			submix_r <= mmrd_pkg::SUBMIX_RST;
			o_reg_rdata <= 8'h00;
			o_submix <= mmrd_pkg::SUBMIX_RST;
			o_win_row <= mmrd_pkg::ROW_TOP;
			o_win_chan <= 6'h00;
			o_remote_active <= mmrd_pkg::CTRL_EN_RST;
			o_hostless <= HOSTLESS_AT_RESET;
		end else begin
			en_r <= en_nxt;
			loop_r <= loop_nxt;
			if (wr_ctrl)
				hl_r <= i_reg_wdata[mmrd_pkg::CTRL_HL_BIT];
			submix_r <= sub_nxt;
			o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
			o_submix <= sub_nxt;
			o_win_row <= win_row_nxt;
			o_win_chan <= win_chan_nxt;
			o_remote_active <= en_nxt;
			o_hostless <= wr_ctrl ? i_reg_wdata[mmrd_pkg::CTRL_HL_BIT] :
				hl_r;
		end
	end

	// ----------------------------------------------------------------
	// Transmit: marker, display, echo
	// ----------------------------------------------------------------
	logic [MW-1:0] mark_cnt_r;
	logic mark_pend_r;
	logic disp_pend_r;
	logic echo_pend_r;
	logic [7:0] echo_r [3];
	logic [7:0] msg_r [3];
	mmrd_pkg::mmrd_tx_type tx_st_r;

	wire mark_tick = en_r & (mark_cnt_r == MARK_LAST);
	wire idle = (tx_st_r == mmrd_pkg::TX_IDLE);
	wire take_mark = idle & mark_pend_r;
	wire take_disp = idle & ~mark_pend_r & disp_pend_r;
	wire take_echo = idle & ~mark_pend_r & ~disp_pend_r & echo_pend_r;
	wire take = take_mark | take_disp | take_echo;
	wire [6:0] disp_cc = mmrd_pkg::SF_DISP_CC + {5'h00, win_row_nxt};
	wire [7:0] ld0 = take_mark ? {mmrd_pkg::CMD_NOTE_ON, mmrd_pkg::MARKER_CH} :
		take_disp ? {mmrd_pkg::CMD_CC, mmrd_pkg::CH_ONE} : echo_r[0];
	wire [7:0] ld1 = take_mark ? {1'b0, mmrd_pkg::MARKER_NOTE} :
		take_disp ? {1'b0, disp_cc} : echo_r[1];
	wire [7:0] ld2 = take_mark ? {1'b0, mmrd_pkg::MARKER_VEL} :
		take_disp ? {2'h0, win_chan_r} : echo_r[2];
	wire adv = o_tx_valid & i_tx_ready;

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mark_cnt_r <= '0;
			mark_pend_r <= 1'b0;
			disp_pend_r <= 1'b0;
			echo_pend_r <= 1'b0;
			echo_r <= '{8'h00, 8'h00, 8'h00};
			msg_r <= '{8'h00, 8'h00, 8'h00};
			tx_st_r <= mmrd_pkg::TX_IDLE;
			o_tx_data <= 8'h00;
			o_tx_valid <= 1'b0;
		end else begin
			mark_cnt_r <= (!en_r || mark_tick) ? '0 : mark_cnt_r + 1'b1;
			mark_pend_r <= mark_tick | (mark_pend_r & ~take_mark);
			disp_pend_r <= (nav & hl_r) | (disp_pend_r & ~take_disp);
			echo_pend_r <= surf | (echo_pend_r & ~take_echo);
			if (surf)
				echo_r <= '{m_st_r, {1'b0, m_d1_r}, {1'b0, m_d2_r}};
			case (tx_st_r)
				mmrd_pkg::TX_IDLE: begin
					if (take) begin
						msg_r <= '{ld0, ld1, ld2};
						o_tx_data <= ld0;
						o_tx_valid <= 1'b1;
						tx_st_r <= mmrd_pkg::TX_B0;
					end
				end
				mmrd_pkg::TX_B0: begin
					if (adv) begin
						o_tx_data <= msg_r[1];
						tx_st_r <= mmrd_pkg::TX_B1;
					end
				end
				mmrd_pkg::TX_B1: begin
					if (adv) begin
						o_tx_data <= msg_r[2];
						tx_st_r <= mmrd_pkg::TX_B2;
					end
				end
				default: begin
					if (adv) begin
						o_tx_valid <= 1'b0;
						tx_st_r <= mmrd_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end

endmodule : mmrd_decoder

//--- design/mmrd_pkg.sv
// Constants shared by the MIDI remote decoder
package mmrd_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 125000;
	localparam int MARKER_MS = 500;
	localparam int MARKER_CYC = CLK_KHZ * MARKER_MS / 1000 * 1000;

	// ----------------------------------------------------------------
	// Message codes
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_NOTE_OFF = 4'h8;
	localparam logic [3:0] CMD_NOTE_ON = 4'h9;
	localparam logic [3:0] CMD_CC = 4'hB;
	localparam logic [3:0] CMD_BEND = 4'hE;
	localparam logic [7:0] SYS_FIRST = 8'hF0;
	localparam logic [7:0] RT_FIRST = 8'hF8;
	localparam logic [3:0] CH_ONE = 4'h0;
	localparam logic [3:0] CH_LAST_FADER = 4'hB;

	// ----------------------------------------------------------------
	// Simple note map
	// ----------------------------------------------------------------
	localparam logic [6:0] NOTE_CUE_MAIN = 7'h3E;
	localparam logic [6:0] NOTE_DIM = 7'h5D;
	localparam logic [6:0] NOTE_TALK = 7'h5E;
	localparam logic [6:0] NOTE_MONO = 7'h2A;
	localparam logic [6:0] NOTE_PH_FIRST = 7'h3F;
	localparam logic [6:0] NOTE_PH_LAST = 7'h42;
	localparam logic [6:0] NOTE_SNAP_FIRST = 7'h36;
	localparam logic [6:0] NOTE_SNAP_LAST = 7'h3D;
	localparam logic [6:0] NOTE_SETUP_LAST = 7'h3B;

	// ----------------------------------------------------------------
	// Controller map and values
	// ----------------------------------------------------------------
	localparam logic [6:0] CC_VOLUME = 7'h07;
	localparam logic [6:0] CC_FADER_FIRST = 7'h66;
	localparam logic [6:0] CC_FADER_LAST = 7'h75;
	localparam logic [6:0] VAL_0DB = 7'h40;
	localparam logic [6:0] VAL_MAX = 7'h7F;
	localparam logic [6:0] VAL_MIN = 7'h00;
	localparam logic [6:0] PAN_CENTER = 7'h40;

	// ----------------------------------------------------------------
	// Control-surface map (strip groups are aligned to eight)
	// ----------------------------------------------------------------
	localparam logic [6:0] SF_REC = 7'h00;
	localparam logic [6:0] SF_MUTE = 7'h10;
	localparam logic [6:0] SF_SEL = 7'h18;
	localparam logic [6:0] SF_PRESS = 7'h20;
	localparam logic [6:0] SF_FKEY = 7'h48;
	localparam logic [6:0] SF_EQ = 7'h4E;
	localparam logic [6:0] SF_STOP = 7'h4F;
	localparam logic [6:0] SF_CH_L = 7'h50;
	localparam logic [6:0] SF_CH_R = 7'h51;
	localparam logic [6:0] SF_BANK_L = 7'h52;
	localparam logic [6:0] SF_BANK_R = 7'h53;
	localparam logic [6:0] SF_UP = 7'h54;
	localparam logic [6:0] SF_DOWN = 7'h55;
	localparam logic [6:0] SF_VPOT_CC = 7'h10;
	localparam logic [6:0] SF_DISP_CC = 7'h60;
	localparam logic [2:0] SF_FKEY_N = 3'h6;

	// ----------------------------------------------------------------
	// Loop marker
	// ----------------------------------------------------------------
	localparam logic [3:0] MARKER_CH = 4'hF;
	localparam logic [6:0] MARKER_NOTE = 7'h7F;
	localparam logic [6:0] MARKER_VEL = 7'h7F;

	// ----------------------------------------------------------------
	// Mixer geometry
	// ----------------------------------------------------------------
	localparam logic [1:0] ROW_TOP = 2'h0;
	localparam logic [1:0] ROW_MID = 2'h1;
	localparam logic [1:0] ROW_BOT = 2'h2;
	localparam logic [5:0] CHAN_STEP = 6'h01;
	localparam logic [5:0] BANK_STEP = 6'h08;
	localparam logic [5:0] WIN_LAST = 6'h38;

	// ----------------------------------------------------------------
	// Cue codes and strip actions
	// ----------------------------------------------------------------
	localparam logic [2:0] CUE_NONE = 3'h0;
	localparam logic [2:0] CUE_MAIN = 3'h1;
	localparam logic [2:0] CUE_PH1 = 3'h2;
	localparam logic [2:0] ACT_VOL = 3'h0;
	localparam logic [2:0] ACT_PAN_REL = 3'h1;
	localparam logic [2:0] ACT_PAN_ABS = 3'h2;
	localparam logic [2:0] ACT_MUTE = 3'h3;
	localparam logic [2:0] ACT_SEL = 3'h4;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_SUBMIX = 4'h2;
	localparam logic [3:0] REG_WINDOW = 4'h3;
	localparam logic [3:0] REG_MAIN_VOL = 4'h4;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_HL_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic CTRL_HL_RST = 1'b0;
	localparam logic [5:0] SUBMIX_RST = 6'h00;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_B0 = 2'b01,
		TX_B1 = 2'b10,
		TX_B2 = 2'b11
	} mmrd_tx_type;

endpackage : mmrd_pkg

//--- testbench/mmrd_ctrl_model.sv
// Model of the external MIDI controller
`timescale 1ns/100ps

module mmrd_ctrl_model (
	input wire logic i_ref_clk,
	input wire logic i_slow,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_tx_ready
);
	logic tog_r = 1'b0;
	logic [7:0] got [$];

	initial begin
		o_rx_data = 8'h00;
		o_rx_valid = 1'b0;
	end

	// Slow mode stalls every other cycle
	assign o_tx_ready = !i_slow || tog_r;
	always @(posedge i_ref_clk) begin
		tog_r <= !tog_r;
		if (i_tx_valid && o_tx_ready) begin
			got.push_back(i_tx_data);
		end
	end

	task automatic send(input logic [3:0] cmd, input int ch,
		input logic [7:0] d1, input logic [7:0] d2);
		logic [7:0] b [3];
		b = '{{cmd, 4'(ch - 1)}, d1, d2};
		for (int i = 0; i < 3; i++) begin
			@(posedge i_ref_clk);
			o_rx_data <= b[i];
			o_rx_valid <= 1'b1;
		end
		@(posedge i_ref_clk);
		o_rx_valid <= 1'b0;
		o_rx_data <= ~b[2];
	endtask : send
endmodule : mmrd_ctrl_model

//--- testbench/mmrd_decoder_sva.sv
// Assertion checker for the MIDI remote decoder
`timescale 1ns/100ps

module mmrd_chk (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_tx_ready,
	input wire logic [7:0] o_tx_data,
	input wire logic o_tx_valid,
	input wire logic o_act_we,
	input wire logic [1:0] o_act_row,
	input wire logic o_main_vol_we,
	input wire logic [6:0] o_main_vol,
	input wire logic [2:0] o_cue_sel,
	input wire logic o_mono,
	input wire logic o_talkback,
	input wire logic o_recall_we,
	input wire logic [2:0] o_recall_idx,
	input wire logic o_remote_active,
	input wire logic o_hostless
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_act_pulse: assert property (o_act_we |=> !o_act_we)
		else $error("action strobe longer than one cycle");
	chk_row_legal: assert property (o_act_we |-> o_act_row != 2'h3)
		else $error("action on nonexistent row");
	chk_vol_cause: assert property ($changed(o_main_vol) |-> o_main_vol_we)
		else $error("main volume moved without strobe");
	chk_cue_range: assert property (o_cue_sel <= 3'h5)
		else $error("cue code out of range");
	chk_recall_pulse: assert property (o_recall_we |=> !o_recall_we)
		else $error("recall strobe longer than one cycle");
	chk_hl_mono: assert property (o_hostless[*3] |-> !o_mono && !o_talkback)
		else $error("mono or talkback on in hostless mode");
	chk_hl_recall: assert property (o_hostless[*4] ##0 o_recall_we |->
		o_recall_idx < 3'h6)
		else $error("hostless recall beyond setup six");
	chk_off_quiet: assert property ((!o_remote_active)[*4] |->
		!o_act_we && !o_recall_we && !o_main_vol_we)
		else $error("action while control disabled");
	chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=>
		o_tx_valid && $stable(o_tx_data))
		else $error("transmit byte dropped before taken");
	chk_tx_status: assert property ($rose(o_tx_valid) |-> o_tx_data[7])
		else $error("message starts without status byte");

	cover property (o_act_we);
	cover property (o_recall_we);
	cover property ($fell(o_remote_active));
endmodule : mmrd_chk

bind mmrd_decoder mmrd_chk u_mmrd_chk (.i_ref_clk, .i_resetn, .i_tx_ready,
	.o_tx_data, .o_tx_valid, .o_act_we, .o_act_row, .o_main_vol_we,
	.o_main_vol, .o_cue_sel, .o_mono, .o_talkback, .o_recall_we,
	.o_recall_idx, .o_remote_active, .o_hostless);

//--- testbench/mmrd_decoder_tb.sv
// Self-checking testbench for the MIDI remote decoder
`timescale 1ns/100ps

module mmrd_decoder_tb;
	localparam int MK = 50;
	logic i_ref_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [7:0] i_rx_data, i_reg_wdata = 8'h00, o_reg_rdata, o_tx_data, rd;
	logic i_rx_valid, i_tx_ready, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
	logic [3:0] i_reg_addr = 4'h0;
	logic o_tx_valid, o_act_we, o_main_vol_we, o_dim, o_mono, o_talkback;
	logic o_master_mute, o_recall_we, o_remote_active, o_hostless;
	logic [2:0] o_act_kind, o_cue_sel, o_recall_idx;
	logic [1:0] o_act_row, o_win_row;
	logic [5:0] o_act_idx, o_submix, o_win_chan;
	logic [6:0] o_act_val, o_main_vol;
	logic [17:0] last_act;
	logic slow = 1'b0;
	int act_cnt = 0, rec_cnt = 0, fails = 0, cmp_count = 0, n;
	logic [7:0] nav [4] = '{8'h51, 8'h53, 8'h50, 8'h52};
	int nav_ex [4] = '{1, 9, 8, 0};

	mmrd_decoder #(.MARKER_CYCLES(MK)) u_mmrd_decoder (.i_ref_clk, .i_resetn,
		.i_rx_data, .i_rx_valid, .i_tx_ready, .i_reg_addr, .i_reg_wdata,
		.i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_tx_data, .o_tx_valid, .o_act_we,
		.o_act_kind, .o_act_row, .o_act_idx, .o_act_val, .o_main_vol_we,
		.o_main_vol, .o_cue_sel, .o_dim, .o_mono, .o_talkback, .o_master_mute,
		.o_recall_we, .o_recall_idx, .o_submix, .o_win_row, .o_win_chan,
		.o_remote_active, .o_hostless);
	mmrd_ctrl_model u_mmrd_ctrl_model (.i_ref_clk, .i_slow(slow),
		.i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid), .o_rx_data(i_rx_data),
		.o_rx_valid(i_rx_valid), .o_tx_ready(i_tx_ready));

	always #4 i_ref_clk = ~i_ref_clk;

	always @(posedge i_ref_clk) begin
		if (o_act_we === 1'b1) begin
			last_act <= {o_act_kind, o_act_row, o_act_idx, o_act_val};
			act_cnt <= act_cnt + 1;
		end
		if (o_recall_we === 1'b1) begin
			rec_cnt <= rec_cnt + 1;
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_reg_wr <= 1'b0;
		#1;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a);
		@(posedge i_ref_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_reg_rd <= 1'b0;
		#1 rd = o_reg_rdata;
	endtask : reg_rd

	task automatic msg(input logic [3:0] c, input int ch,
		input logic [7:0] a, input logic [7:0] b);
		u_mmrd_ctrl_model.send(c, ch, a, b);
		repeat (6) @(posedge i_ref_clk);
		#1;
	endtask : msg

	function automatic logic seen3(input logic [7:0] a, b, c);
		for (int i = 0; i + 2 < u_mmrd_ctrl_model.got.size(); i++) begin
			if (u_mmrd_ctrl_model.got[i] === a &&
				u_mmrd_ctrl_model.got[i + 1] === b &&
				u_mmrd_ctrl_model.got[i + 2] === c) begin
				return 1'b1;
			end
		end
		return 1'b0;
	endfunction : seen3

	task automatic report_and_stop();
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (20000) @(posedge i_ref_clk);
		fails++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		@(posedge i_ref_clk);
		#1;
		chk("main_vol", 8'h40, o_main_vol);
		reg_rd(mmrd_pkg::REG_CTRL);
		chk("ctrl", 8'h01, rd);
		for (int ch = 0; ch < 12; ch++) begin
			int cc;
			cc = 102 + (ch % 4) * 5;
			msg(4'hB, ch + 1, 8'(cc), 8'(ch * 11));
			chk("fader", {mmrd_pkg::ACT_VOL, 2'(ch / 4),
				6'((ch % 4) * 16 + cc - 102), 7'(ch * 11)}, last_act);
		end
		msg(4'hB, 13, 8'h66, 8'h40);
		msg(4'hB, 1, 8'h65, 8'h40);
		msg(4'hB, 1, 8'h76, 8'h7F);
		chk("act_cnt", 12, act_cnt);
		msg(4'hB, 1, 8'h07, 8'h55);
		msg(4'hB, 2, 8'h07, 8'h11);
		chk("main_vol", 8'h55, o_main_vol);
		reg_rd(mmrd_pkg::REG_MAIN_VOL);
		chk("vol_reg", 8'h55, rd);
		msg(4'h9, 1, 8'h3E, 8'h7F);
		chk("cue", 1, o_cue_sel);
		for (int i = 0; i < 4; i++) begin
			msg(4'h9, 1, 8'(8'h3F + i), 8'h7F);
			chk("cue", 2 + i, o_cue_sel);
		end
		msg(4'h9, 1, 8'h5D, 8'h7F);
		msg(4'h9, 1, 8'h5D, 8'h00);
		msg(4'h9, 2, 8'h5D, 8'h7F);
		msg(4'h8, 1, 8'h5D, 8'h40);
		chk("dim", 1, o_dim);
		msg(4'h9, 1, 8'h5E, 8'h7F);
		chk("talk", 1, o_talkback);
		msg(4'h9, 1, 8'h2A, 8'h7F);
		chk("mono", 1, o_mono);
		for (int i = 0; i < 8; i++) begin
			msg(4'h9, 1, 8'(8'h36 + i), 8'h7F);
			chk("recall", i, o_recall_idx);
		end
		chk("rec_cnt", 8, rec_cnt);
		reg_wr(mmrd_pkg::REG_CTRL, 8'h03);
		chk("hostless", 1, o_hostless);
		slow = 1'b1;
		msg(4'h9, 1, 8'h2A, 8'h7F);
		chk("mono", 0, o_mono);
		chk("talk", 0, o_talkback);
		msg(4'h9, 1, 8'h3E, 8'h7F);
		chk("cue", 5, o_cue_sel);
		msg(4'h9, 1, 8'h55, 8'h7F);
		chk("row", 2, o_win_row);
		reg_rd(mmrd_pkg::REG_WINDOW);
		chk("window", 8'h80, rd);
		repeat (40) @(posedge i_ref_clk);
		chk("display", 1, seen3(8'hB0, 8'h62, 8'h00));
		chk("echo", 1, seen3(8'h90, 8'h55, 8'h7F));
		msg(4'h9, 1, 8'h54, 8'h7F);
		chk("row", 0, o_win_row);
		for (int i = 0; i < 4; i++) begin
			msg(4'h9, 1, nav[i], 8'h7F);
			chk("chan", nav_ex[i], o_win_chan);
		end
		msg(4'h9, 1, 8'h4F, 8'h7F);
		chk("dim", 0, o_dim);
		msg(4'h9, 1, 8'h4E, 8'h7F);
		chk("mute", 1, o_master_mute);
		msg(4'h9, 1, 8'h5D, 8'h7F);
		chk("dim", 1, o_dim);
		n = rec_cnt;
		msg(4'h9, 1, 8'h3C, 8'h7F);
		chk("rec_cnt", n, rec_cnt);
		msg(4'h9, 1, 8'h3B, 8'h7F);
		chk("recall", 5, o_recall_idx);
		msg(4'h9, 1, 8'h48, 8'h7F);
		chk("recall", 0, o_recall_idx);
		msg(4'hE, 1, 8'h00, 8'h50);
		chk("bend", {mmrd_pkg::ACT_VOL, 15'h0050}, last_act);
		msg(4'h9, 1, 8'h20, 8'h7F);
		chk("press", {mmrd_pkg::ACT_PAN_ABS, 15'h0040}, last_act);
		msg(4'h9, 1, 8'h10, 8'h7F);
		chk("strip", mmrd_pkg::ACT_MUTE, last_act[17:15]);
		msg(4'h9, 1, 8'h18, 8'h7F);
		chk("strip", mmrd_pkg::ACT_SEL, last_act[17:15]);
		msg(4'hB, 1, 8'h12, 8'h05);
		chk("vpot", {mmrd_pkg::ACT_PAN_REL, 15'h0105}, last_act);
		n = act_cnt;
		msg(4'hB, 5, 8'h66, 8'h10);
		chk("act_cnt", n, act_cnt);
		reg_wr(mmrd_pkg::REG_SUBMIX, 8'h05);
		@(posedge i_ref_clk);
		#1;
		chk("submix", 5, o_submix);
		msg(4'h9, 1, 8'h03, 8'h7F);
		chk("submix", 3, o_submix);
		reg_wr(mmrd_pkg::REG_CTRL, 8'h01);
		slow = 1'b0;
		repeat (60) @(posedge i_ref_clk);
		chk("marker", 1, seen3(8'h9F, 8'h7F, 8'h7F));
		msg(4'h9, 16, 8'h7F, 8'h7F);
		chk("active", 0, o_remote_active);
		reg_rd(mmrd_pkg::REG_STATUS);
		chk("loop", 1, rd[0]);
		n = act_cnt;
		msg(4'hB, 1, 8'h66, 8'h10);
		chk("act_cnt", n, act_cnt);
		reg_wr(mmrd_pkg::REG_CTRL, 8'h01);
		msg(4'hB, 1, 8'h66, 8'h10);
		chk("act_cnt", n + 1, act_cnt);
		reg_rd(4'hF);
		chk("unmapped", 0, rd);
		report_and_stop();
	end
endmodule : mmrd_decoder_tb
